// ### rtl/gpcde_top.sv
// Port C read path, port D and port E pin logic with AHB-Lite registers
// Function
// - Port C data read gives latch where direction is 1, pin where 0.
// - Data latch writes land, except port C pin 2 with clock-out enable set; writing an input pin never changes its reading.
// - With clock-out enable set, port C pin 2 reads 0 and ignores writes.
// - Port D has eight bidirectional pins with latches, two shared with timers.
// - Port D latches are read/write and untouched by reset.
// - Port D pin 6 feeds timer A external clock when its prescaler is 111.
// - Port D pin 4 feeds timer B external clock when its prescaler is 111.
// - Port D direction 1 enables output buffer, except on pin 6 or 4 while its timer prescaler is 111; reset clears all directions.
// - Port D data read gives latch where direction is 1, pin where 0.
// - Port D pull-up acts only on inputs, dropped at once for outputs.
// - Pull-up enable 1 connects, 0 disconnects, each bit independent.
// - Port E latches read/write, direction per bit, untouched by reset.
// - Port E pin 7 is SPI clock, out in master, in in slave mode.
// - Port E pin 6 is SPI MOSI while SPI is enabled.
// - Port E pin 5 is SPI MISO while SPI is enabled.
// - Port E pin 4 is SPI slave select input only in enabled slave mode.
// - Port E pins 3 and 2 are timer A channels when edge/level select nonzero.
// - Port E pin 1 is SCI receive input while SCI is enabled.
// - Port E pin 0 is SCI transmit output while SCI is enabled.
// - Peripheral-owned port E pins ignore direction; direction still picks read source.
// - Port E data read gives latch where direction is 1, pin where 0.
`timescale 1ns/1ns
module gpcde_top (
	input wire logic i_clk,
	input wire logic i_reset,
	input wire logic i_hsel,
	input wire logic [31:0] i_haddr,
	input wire logic [1:0] i_htrans,
	input wire logic i_hwrite,
	input wire logic [2:0] i_hsize,
	input wire logic [31:0] i_hwdata,
	input wire logic i_hready,
	output logic o_hreadyout,
	output logic o_hresp,
	output logic [31:0] o_hrdata,
	input wire logic [5:0] i_portc_pin,
	output logic [5:0] o_portc_out,
	output logic [5:0] o_portc_oe_n,
	input wire logic i_sysclk_level,
	input wire logic [7:0] i_portd_pin,
	output logic [7:0] o_portd_out,
	output logic [7:0] o_portd_oe_n,
	output logic [7:0] o_portd_pullup_on,
	input wire logic [2:0] i_timer_a_prescaler_select,
	input wire logic [2:0] i_timer_b_prescaler_select,
	output logic o_timer_a_ext_clock,
	output logic o_timer_b_ext_clock,
	input wire logic [7:0] i_porte_pin,
	output logic [7:0] o_porte_out,
	output logic [7:0] o_porte_oe_n,
	output logic [7:0] o_porte_pin_level,
	input wire logic i_spi_enable_bit,
	input wire logic i_spi_master_bit,
	input wire logic [2:0] i_spi_pin_oe,
	input wire logic [2:0] i_spi_pin_out,
	input wire logic [1:0] i_timer_a_ch0_edge_level_select,
	input wire logic [1:0] i_timer_a_ch1_edge_level_select,
	input wire logic [1:0] i_timer_a_ch_oe,
	input wire logic [1:0] i_timer_a_ch_out,
	input wire logic i_sci_enable_bit,
	input wire logic i_sci_txd
);

	// ==========================================================
	// State
	typedef struct packed {
		logic [gpcde_pkg::PC_W-1:0] pc_lat;
		logic [gpcde_pkg::PC_W-1:0] pc_ddr;
		logic pc_clk_en;
		logic [gpcde_pkg::PORT_W-1:0] pd_lat;
		logic [gpcde_pkg::PORT_W-1:0] pd_ddr;
		logic [gpcde_pkg::PORT_W-1:0] pd_pue;
		logic [gpcde_pkg::PORT_W-1:0] pe_lat;
		logic [gpcde_pkg::PORT_W-1:0] pe_ddr;
		logic wr_pend;
		logic [gpcde_pkg::IDX_W-1:0] wr_idx;
		logic [gpcde_pkg::DATA_W-1:0] hrdata;
		logic hready;
		logic hresp;
		logic [gpcde_pkg::PC_W-1:0] pc_s1;
		logic [gpcde_pkg::PC_W-1:0] pc_s2;
		logic [gpcde_pkg::PORT_W-1:0] pd_s1;
		logic [gpcde_pkg::PORT_W-1:0] pd_s2;
		logic [gpcde_pkg::PORT_W-1:0] pe_s1;
		logic [gpcde_pkg::PORT_W-1:0] pe_s2;
		logic [gpcde_pkg::PC_W-1:0] pc_out;
		logic [gpcde_pkg::PC_W-1:0] pc_oe_n;
		logic [gpcde_pkg::PORT_W-1:0] pd_out;
		logic [gpcde_pkg::PORT_W-1:0] pd_oe_n;
		logic [gpcde_pkg::PORT_W-1:0] pd_pu;
		logic [gpcde_pkg::PORT_W-1:0] pe_out;
		logic [gpcde_pkg::PORT_W-1:0] pe_oe_n;
		logic [gpcde_pkg::PORT_W-1:0] pe_level;
		logic ta_clk;
		logic tb_clk;
	} gpcde_state_s;

	gpcde_state_s state_r;
	gpcde_state_s state_nxt;
	logic addr_ok;
	logic acc_valid;
	logic [gpcde_pkg::IDX_W-1:0] acc_idx;

	// ==========================================================
	// Helpers
	// Direction picks latch or sampled pin for each bit
	function automatic logic [gpcde_pkg::PORT_W-1:0] read_mix(
		input logic [gpcde_pkg::PORT_W-1:0] ddr,
		input logic [gpcde_pkg::PORT_W-1:0] lat,
		input logic [gpcde_pkg::PORT_W-1:0] pin
	);
		read_mix = (lat & ddr) | (pin & ~ddr);
	endfunction : read_mix

	// Register read value for one index
	function automatic logic [gpcde_pkg::DATA_W-1:0] read_reg(
		input logic [gpcde_pkg::IDX_W-1:0] idx,
		input gpcde_state_s st
	);
		logic [gpcde_pkg::PORT_W-1:0] v;
		logic [gpcde_pkg::PORT_W-1:0] mix;
		v = '0;
		mix = read_mix({2'h0, st.pc_ddr}, {2'h0, st.pc_lat}, {2'h0, st.pc_s2});
		case (idx)
			gpcde_pkg::IDX_PORTC_DATA: begin
				v[gpcde_pkg::PC_W-1:0] = mix[gpcde_pkg::PC_W-1:0];
				if (st.pc_clk_en) begin
					v[gpcde_pkg::PC_CLK_PIN] = 1'b0;
				end
			end
			gpcde_pkg::IDX_PORTD_DATA: v = read_mix(st.pd_ddr, st.pd_lat, st.pd_s2);
			gpcde_pkg::IDX_PORTE_DATA: v = read_mix(st.pe_ddr, st.pe_lat, st.pe_s2);
			gpcde_pkg::IDX_PORTC_DIR: begin
				v[gpcde_pkg::PC_W-1:0] = st.pc_ddr;
				v[gpcde_pkg::PC_CLK_EN_BIT] = st.pc_clk_en;
			end
			gpcde_pkg::IDX_PORTD_DIR: v = st.pd_ddr;
			gpcde_pkg::IDX_PORTE_DIR: v = st.pe_ddr;
			gpcde_pkg::IDX_PORTD_PULLUP: v = st.pd_pue;
			default: v = '0;
		endcase
		read_reg = {{(gpcde_pkg::DATA_W-gpcde_pkg::PORT_W){1'b0}}, v};
	endfunction : read_reg

	// ==========================================================
	// Bus address phase decode
	assign addr_ok = (i_haddr[gpcde_pkg::ADDR_MSB:gpcde_pkg::IDX_MSB+1] == '0)
		&& (i_haddr[gpcde_pkg::IDX_LSB-1:0] == '0)
		&& (i_hsize == gpcde_pkg::HSIZE_WORD);
	assign acc_valid = i_hsel && i_htrans[gpcde_pkg::HTRANS_ACTIVE_BIT] && i_hready && addr_ok;
	assign acc_idx = i_haddr[gpcde_pkg::IDX_MSB:gpcde_pkg::IDX_LSB];

	// ==========================================================
	// Next state
	always_comb begin
		state_nxt = state_r;
		state_nxt.hready = 1'b1;
		state_nxt.hresp = gpcde_pkg::HRESP_OKAY;
		// Data phase of a write commits here
		if (state_r.wr_pend) begin
			case (state_r.wr_idx)
				gpcde_pkg::IDX_PORTC_DATA: begin
					state_nxt.pc_lat = i_hwdata[gpcde_pkg::PC_W-1:0];
					if (state_r.pc_clk_en) begin
						state_nxt.pc_lat[gpcde_pkg::PC_CLK_PIN] =
							state_r.pc_lat[gpcde_pkg::PC_CLK_PIN];
					end
				end
				gpcde_pkg::IDX_PORTD_DATA: state_nxt.pd_lat = i_hwdata[gpcde_pkg::PORT_W-1:0];
				gpcde_pkg::IDX_PORTE_DATA: state_nxt.pe_lat = i_hwdata[gpcde_pkg::PORT_W-1:0];
				gpcde_pkg::IDX_PORTC_DIR: begin
					state_nxt.pc_ddr = i_hwdata[gpcde_pkg::PC_W-1:0];
					state_nxt.pc_clk_en = i_hwdata[gpcde_pkg::PC_CLK_EN_BIT];
				end
				gpcde_pkg::IDX_PORTD_DIR: state_nxt.pd_ddr = i_hwdata[gpcde_pkg::PORT_W-1:0];
				gpcde_pkg::IDX_PORTE_DIR: state_nxt.pe_ddr = i_hwdata[gpcde_pkg::PORT_W-1:0];
				gpcde_pkg::IDX_PORTD_PULLUP: state_nxt.pd_pue = i_hwdata[gpcde_pkg::PORT_W-1:0];
				default: state_nxt.wr_pend = 1'b0;
			endcase
		end
		// Address phase, read answers with any write just committed
		state_nxt.wr_pend = acc_valid && i_hwrite;
		state_nxt.wr_idx = acc_idx;
		state_nxt.hrdata = (acc_valid && !i_hwrite) ? read_reg(acc_idx, state_nxt)
			: gpcde_pkg::RDATA_RESET;
		// Pin synchronisers, shifted after the read so only stage two feeds it
		state_nxt.pc_s1 = i_portc_pin;
		state_nxt.pc_s2 = state_r.pc_s1;
		state_nxt.pd_s1 = i_portd_pin;
		state_nxt.pd_s2 = state_r.pd_s1;
		state_nxt.pe_s1 = i_porte_pin;
		state_nxt.pe_s2 = state_r.pe_s1;
		// Port C drive, pin 2 may carry the system clock
		state_nxt.pc_out = state_nxt.pc_lat;
		state_nxt.pc_oe_n = ~state_nxt.pc_ddr;
		if (state_nxt.pc_clk_en) begin
			state_nxt.pc_out[gpcde_pkg::PC_CLK_PIN] = i_sysclk_level;
			state_nxt.pc_oe_n[gpcde_pkg::PC_CLK_PIN] = 1'b0;
		end
		// Port D drive, pull-ups and timer clock taps
		state_nxt.pd_out = state_nxt.pd_lat;
		state_nxt.pd_oe_n = ~state_nxt.pd_ddr;
		state_nxt.pd_pu = state_nxt.pd_pue & ~state_nxt.pd_ddr;
		state_nxt.ta_clk = 1'b0;
		state_nxt.tb_clk = 1'b0;
		if (i_timer_a_prescaler_select == gpcde_pkg::PS_EXT_CLOCK) begin
			state_nxt.pd_oe_n[gpcde_pkg::PD_TA_CLK_PIN] = 1'b1;
			state_nxt.ta_clk = state_r.pd_s2[gpcde_pkg::PD_TA_CLK_PIN];
		end
		if (i_timer_b_prescaler_select == gpcde_pkg::PS_EXT_CLOCK) begin
			state_nxt.pd_oe_n[gpcde_pkg::PD_TB_CLK_PIN] = 1'b1;
			state_nxt.tb_clk = state_r.pd_s2[gpcde_pkg::PD_TB_CLK_PIN];
		end
		// Port E drive, peripherals override latch and direction
		state_nxt.pe_out = state_nxt.pe_lat;
		state_nxt.pe_oe_n = ~state_nxt.pe_ddr;
		state_nxt.pe_level = state_r.pe_s2;
		if (i_spi_enable_bit) begin
			state_nxt.pe_out[gpcde_pkg::PE_SCK] = i_spi_pin_out[gpcde_pkg::SPI_SCK];
			state_nxt.pe_oe_n[gpcde_pkg::PE_SCK] = ~i_spi_pin_oe[gpcde_pkg::SPI_SCK];
			state_nxt.pe_out[gpcde_pkg::PE_MOSI] = i_spi_pin_out[gpcde_pkg::SPI_MOSI];
			state_nxt.pe_oe_n[gpcde_pkg::PE_MOSI] = ~i_spi_pin_oe[gpcde_pkg::SPI_MOSI];
			state_nxt.pe_out[gpcde_pkg::PE_MISO] = i_spi_pin_out[gpcde_pkg::SPI_MISO];
			state_nxt.pe_oe_n[gpcde_pkg::PE_MISO] = ~i_spi_pin_oe[gpcde_pkg::SPI_MISO];
			if (!i_spi_master_bit) begin
				state_nxt.pe_oe_n[gpcde_pkg::PE_SS] = 1'b1;
			end
		end
		if (i_timer_a_ch1_edge_level_select != gpcde_pkg::ELS_GPIO) begin
			state_nxt.pe_out[gpcde_pkg::PE_CH1] = i_timer_a_ch_out[1];
			state_nxt.pe_oe_n[gpcde_pkg::PE_CH1] = ~i_timer_a_ch_oe[1];
		end
		if (i_timer_a_ch0_edge_level_select != gpcde_pkg::ELS_GPIO) begin
			state_nxt.pe_out[gpcde_pkg::PE_CH0] = i_timer_a_ch_out[0];
			state_nxt.pe_oe_n[gpcde_pkg::PE_CH0] = ~i_timer_a_ch_oe[0];
		end
		if (i_sci_enable_bit) begin
			state_nxt.pe_oe_n[gpcde_pkg::PE_RXD] = 1'b1;
			state_nxt.pe_out[gpcde_pkg::PE_TXD] = i_sci_txd;
			state_nxt.pe_oe_n[gpcde_pkg::PE_TXD] = 1'b0;
		end
	end

	// ==========================================================
	// State register, data latches keep their contents through reset
	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			state_r.pc_ddr <= '0;
			state_r.pc_clk_en <= 1'b0;
			state_r.pd_ddr <= gpcde_pkg::DIR_RESET;
			state_r.pd_pue <= gpcde_pkg::PULLUP_RESET;
			state_r.pe_ddr <= gpcde_pkg::DIR_RESET;
			state_r.wr_pend <= 1'b0;
			state_r.wr_idx <= '0;
			state_r.hrdata <= gpcde_pkg::RDATA_RESET;
			state_r.hready <= 1'b1;
			state_r.hresp <= gpcde_pkg::HRESP_OKAY;
			state_r.pc_s1 <= '0;
			state_r.pc_s2 <= '0;
			state_r.pd_s1 <= '0;
			state_r.pd_s2 <= '0;
			state_r.pe_s1 <= '0;
			state_r.pe_s2 <= '0;
			state_r.pc_out <= '0;
			state_r.pc_oe_n <= '1;
			state_r.pd_out <= '0;
			state_r.pd_oe_n <= gpcde_pkg::OE_N_RESET;
			state_r.pd_pu <= '0;
			state_r.pe_out <= '0;
			state_r.pe_oe_n <= gpcde_pkg::OE_N_RESET;
			state_r.pe_level <= '0;
			state_r.ta_clk <= 1'b0;
			state_r.tb_clk <= 1'b0;
			// Data latch fields are not listed, so they hold
		end else begin
			state_r <= state_nxt;
		end
	end

	// ==========================================================
	// Outputs
	assign o_hreadyout = state_r.hready;
	assign o_hresp = state_r.hresp;
	assign o_hrdata = state_r.hrdata;
	assign o_portc_out = state_r.pc_out;
	assign o_portc_oe_n = state_r.pc_oe_n;
	assign o_portd_out = state_r.pd_out;
	assign o_portd_oe_n = state_r.pd_oe_n;
	assign o_portd_pullup_on = state_r.pd_pu;
	assign o_timer_a_ext_clock = state_r.ta_clk;
	assign o_timer_b_ext_clock = state_r.tb_clk;
	assign o_porte_out = state_r.pe_out;
	assign o_porte_oe_n = state_r.pe_oe_n;
	assign o_porte_pin_level = state_r.pe_level;

	// ==========================================================
	// Checks
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_reset);

	sequence s_wr(logic [5:0] idx);
		acc_valid && i_hwrite && (acc_idx == idx) ##1 1'b1;
	endsequence

	sequence s_rd(logic [5:0] idx);
		acc_valid && !i_hwrite && (acc_idx == idx) && !state_r.wr_pend;
	endsequence

	chk_latch_write_lands: assert property (s_wr(gpcde_pkg::IDX_PORTD_DATA) |=>
		state_r.pd_lat == $past(i_hwdata[7:0]))
		else $error("port D latch missed a write");
	chk_portd_dir_drive: assert property (s_wr(gpcde_pkg::IDX_PORTD_DIR) |=>
		o_portd_oe_n[3:0] == ~$past(i_hwdata[3:0]))
		else $error("port D buffers do not follow direction");
	chk_dir_reset_clear: assert property ($past(i_reset) |->
		(state_r.pd_ddr == '0) && (o_portd_oe_n == '1))
		else $error("port D direction not cleared by reset");
	chk_pullup_input_only: assert property ((o_portd_pullup_on & ~o_portd_oe_n) == '0)
		else $error("pull-up on while pin drives");
	chk_pullup_follow_bits: assert property (
		s_wr(gpcde_pkg::IDX_PORTD_PULLUP) ##0 (state_r.pd_ddr == '0) |=>
		o_portd_pullup_on == $past(i_hwdata[7:0]))
		else $error("pull-up does not follow its enable");
	chk_portd_read_mix: assert property (s_rd(gpcde_pkg::IDX_PORTD_DATA) |=>
		o_hrdata[7:0] == ((state_r.pd_lat & state_r.pd_ddr)
		| ($past(state_r.pd_s2) & ~state_r.pd_ddr)))
		else $error("port D read source wrong");
	chk_portc_pin2_reads_zero: assert property (s_rd(gpcde_pkg::IDX_PORTC_DATA) ##0
		state_r.pc_clk_en |=> !o_hrdata[2])
		else $error("port C pin 2 read not zero with clock out");
	chk_ta_clock_route: assert property (
		i_timer_a_prescaler_select == gpcde_pkg::PS_EXT_CLOCK |=>
		o_timer_a_ext_clock == $past(state_r.pd_s2[6]) && o_portd_oe_n[6])
		else $error("timer A clock not routed");
	chk_tb_clock_gate: assert property (
		i_timer_b_prescaler_select != gpcde_pkg::PS_EXT_CLOCK |=> !o_timer_b_ext_clock)
		else $error("timer B clock leaks");
	chk_spi_miso_drive: assert property (i_spi_enable_bit |=>
		o_porte_out[5] == $past(i_spi_pin_out[0]) && o_porte_oe_n[5] == !$past(i_spi_pin_oe[0]))
		else $error("MISO pin not driven by SPI");
	chk_ss_slave_input: assert property (i_spi_enable_bit && !i_spi_master_bit |=>
		o_porte_oe_n[4])
		else $error("slave select not an input");
	chk_sci_pins_owned: assert property (i_sci_enable_bit |=>
		o_porte_oe_n[1] && !o_porte_oe_n[0] && o_porte_out[0] == $past(i_sci_txd))
		else $error("SCI pins not owned");
	chk_rxd_gpio_free: assert property (!i_sci_enable_bit |=>
		o_porte_oe_n[gpcde_pkg::PE_RXD] == !state_r.pe_ddr[gpcde_pkg::PE_RXD])
		else $error("receive pin not back to port use");
	chk_sck_pin_owned: assert property (i_spi_enable_bit |=>
		o_porte_out[gpcde_pkg::PE_SCK] == $past(i_spi_pin_out[gpcde_pkg::SPI_SCK])
		&& o_porte_oe_n[gpcde_pkg::PE_SCK] == !$past(i_spi_pin_oe[gpcde_pkg::SPI_SCK]))
		else $error("serial clock pin not driven by SPI");
	chk_mosi_pin_owned: assert property (i_spi_enable_bit |=>
		o_porte_out[gpcde_pkg::PE_MOSI] == $past(i_spi_pin_out[gpcde_pkg::SPI_MOSI])
		&& o_porte_oe_n[gpcde_pkg::PE_MOSI] == !$past(i_spi_pin_oe[gpcde_pkg::SPI_MOSI]))
		else $error("MOSI pin not driven by SPI");
	chk_tach_pins_owned: assert property (
		i_timer_a_ch1_edge_level_select != gpcde_pkg::ELS_GPIO |=>
		o_porte_out[gpcde_pkg::PE_CH1] == $past(i_timer_a_ch_out[1])
		&& o_porte_oe_n[gpcde_pkg::PE_CH1] == !$past(i_timer_a_ch_oe[1]))
		else $error("timer channel 1 pin not owned");
	chk_clk_out_drive: assert property (state_r.pc_clk_en && !state_r.wr_pend |=>
		!o_portc_oe_n[gpcde_pkg::PC_CLK_PIN]
		&& o_portc_out[gpcde_pkg::PC_CLK_PIN] == $past(i_sysclk_level))
		else $error("system clock not on port C pin 2");
	chk_pc2_write_guard: assert property (
		s_wr(gpcde_pkg::IDX_PORTC_DATA) ##0 state_r.pc_clk_en |=>
		state_r.pc_lat[gpcde_pkg::PC_CLK_PIN] == $past(state_r.pc_lat[gpcde_pkg::PC_CLK_PIN]))
		else $error("port C pin 2 latch changed with clock out");
	chk_porte_read_mix: assert property (s_rd(gpcde_pkg::IDX_PORTE_DATA) |=>
		o_hrdata[7:0] == ((state_r.pe_lat & state_r.pe_ddr)
		| ($past(state_r.pe_s2) & ~state_r.pe_ddr)))
		else $error("port E read source wrong");

endmodule : gpcde_top

// ### rtl/gpcde_pkg.sv
// Constants shared by the port C, D and E pin logic
package gpcde_pkg;
	// ==========================================================
	// Widths
	localparam int PORT_W = 8;
	localparam int PC_W = 6;
	localparam int DATA_W = 32;
	localparam int IDX_W = 6;
	// ==========================================================
	// Register indices, byte address is four times the index
	localparam logic [IDX_W-1:0] IDX_PORTC_DATA = 6'h02;
	localparam logic [IDX_W-1:0] IDX_PORTD_DATA = 6'h03;
	localparam logic [IDX_W-1:0] IDX_PORTE_DATA = 6'h08;
	localparam logic [IDX_W-1:0] IDX_PORTC_DIR = 6'h10;
	localparam logic [IDX_W-1:0] IDX_PORTD_DIR = 6'h11;
	localparam logic [IDX_W-1:0] IDX_PORTE_DIR = 6'h12;
	localparam logic [IDX_W-1:0] IDX_PORTD_PULLUP = 6'h13;
	localparam int IDX_LSB = 2;
	localparam int IDX_MSB = 7;
	localparam int ADDR_MSB = 31;
	// ==========================================================
	// Bus encodings
	localparam int HTRANS_ACTIVE_BIT = 1;
	localparam logic [2:0] HSIZE_WORD = 3'h2;
	localparam logic HRESP_OKAY = 1'h0;
	// ==========================================================
	// Field positions and reset values
	localparam int PC_CLK_PIN = 2;
	localparam int PC_CLK_EN_BIT = 7;
	localparam int PD_TA_CLK_PIN = 6;
	localparam int PD_TB_CLK_PIN = 4;
	localparam int PE_SCK = 7;
	localparam int PE_MOSI = 6;
	localparam int PE_MISO = 5;
	localparam int PE_SS = 4;
	localparam int PE_CH1 = 3;
	localparam int PE_CH0 = 2;
	localparam int PE_RXD = 1;
	localparam int PE_TXD = 0;
	localparam int SPI_SCK = 2;
	localparam int SPI_MOSI = 1;
	localparam int SPI_MISO = 0;
	localparam logic [2:0] PS_EXT_CLOCK = 3'h7;
	localparam logic [1:0] ELS_GPIO = 2'h0;
	localparam logic [PORT_W-1:0] DIR_RESET = 8'h00;
	localparam logic [PORT_W-1:0] PULLUP_RESET = 8'h00;
	localparam logic [PORT_W-1:0] OE_N_RESET = 8'hff;
	localparam logic [DATA_W-1:0] RDATA_RESET = 32'h0;
endpackage : gpcde_pkg

// ### verif/gpcde_pin_model.sv
// Pad model for one port: chip drive, outside drivers, pull-ups
`timescale 1ns/1ns
module gpcde_pin_model #(
	parameter int W = 8
) (
	input wire logic i_clk,
	input wire logic [W-1:0] i_out,
	input wire logic [W-1:0] i_oe_n,
	input wire logic [W-1:0] i_pullup,
	input wire logic [W-1:0] i_ext_val,
	input wire logic [W-1:0] i_ext_en,
	output logic [W-1:0] o_pin
);
	logic flip_r = 1'b0;

	// ==========================================================
	// Floating pads wander every cycle, never hold a stale level
	always_ff @(posedge i_clk) begin
		flip_r <= ~flip_r;
	end

	// Chip drive wins, then the outside driver, then the pull-up
	always_comb begin
		for (int b = 0; b < W; b++) begin
			if (!i_oe_n[b]) o_pin[b] = i_out[b];
			else if (i_ext_en[b]) o_pin[b] = i_ext_val[b];
			else if (i_pullup[b]) o_pin[b] = 1'b1;
			else o_pin[b] = flip_r;
		end
	end
endmodule : gpcde_pin_model

// ### verif/test_gpio_ports_c_d_e.sv
// Self-checking bench for the port C, D and E pin logic
`timescale 1ns/1ns
module test_gpio_ports_c_d_e;
	logic clk, rst, hsel, hwr, hrdy, hresp, sclk, tca, tcb, spi_enable_bit, spm, sce, txd, dph;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0] htrans, els0, els1, coe, cout;
	logic [2:0] hsize, psa, psb, soe, sout;
	logic [5:0] pcp, pco, pcoe, ext_c, en_c;
	logic [7:0] pdp, pdo, pdoe, pdpu, pep, peo, peoe, pel, ext_d, ext_e, en_d, en_e;
	logic [31:0] exp_q[$];
	int error_cnt, compares;

	// ==========================================================
	// Design and pad models
	gpcde_top dut_u (.i_clk(clk), .i_reset(rst), .i_hsel(hsel), .i_haddr(haddr),
		.i_htrans(htrans), .i_hwrite(hwr), .i_hsize(hsize), .i_hwdata(hwdata),
		.i_hready(hrdy), .o_hreadyout(hrdy), .o_hresp(hresp), .o_hrdata(hrdata),
		.i_portc_pin(pcp), .o_portc_out(pco), .o_portc_oe_n(pcoe), .i_sysclk_level(sclk),
		.i_portd_pin(pdp), .o_portd_out(pdo), .o_portd_oe_n(pdoe), .o_portd_pullup_on(pdpu),
		.i_timer_a_prescaler_select(psa), .i_timer_b_prescaler_select(psb),
		.o_timer_a_ext_clock(tca), .o_timer_b_ext_clock(tcb), .i_porte_pin(pep),
		.o_porte_out(peo), .o_porte_oe_n(peoe), .o_porte_pin_level(pel),
		.i_spi_enable_bit(spi_enable_bit), .i_spi_master_bit(spm), .i_spi_pin_oe(soe),
		.i_spi_pin_out(sout), .i_timer_a_ch0_edge_level_select(els0),
		.i_timer_a_ch1_edge_level_select(els1), .i_timer_a_ch_oe(coe),
		.i_timer_a_ch_out(cout), .i_sci_enable_bit(sce), .i_sci_txd(txd));
	gpcde_pin_model #(.W(6)) pc_m (.i_clk(clk), .i_out(pco), .i_oe_n(pcoe),
		.i_pullup(6'h00), .i_ext_val(ext_c), .i_ext_en(en_c), .o_pin(pcp));
	gpcde_pin_model #(.W(8)) pd_m (.i_clk(clk), .i_out(pdo), .i_oe_n(pdoe),
		.i_pullup(pdpu), .i_ext_val(ext_d), .i_ext_en(en_d), .o_pin(pdp));
	gpcde_pin_model #(.W(8)) pe_m (.i_clk(clk), .i_out(peo), .i_oe_n(peoe),
		.i_pullup(8'h00), .i_ext_val(ext_e), .i_ext_en(en_e), .o_pin(pep));

	// Free-running bus clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// ==========================================================
	// Compare, report and bus tasks
	task automatic finish_test;
		$display("Checks %0d, mismatches %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : finish_test

	task automatic chk_rd(input logic [31:0] e, s);
		compares++;
		if (s !== e) begin
			error_cnt++;
			$display("MISMATCH hrdata expected %h seen %h", e, s);
		end
	endtask : chk_rd

	task automatic chk_pin(input string nm, input logic [7:0] e, s);
		compares++;
		if (s !== e) begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", nm, e, s);
		end
	endtask : chk_pin

	// Bounded wait for ready at a rising edge
	task automatic wait_rdy;
		int n;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (hrdy !== 1'b1 && n < 50);
		if (hrdy !== 1'b1) begin
			error_cnt++;
			finish_test;
		end
	endtask : wait_rdy

	// One single word transfer; reads leave their expected word in the queue
	task automatic bus(input logic wr, input logic [5:0] idx, input logic [7:0] v);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwr <= wr;
		haddr <= {24'h0, idx, 2'h0};
		wait_rdy;
		if (!wr) exp_q.push_back({24'h0, v});
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= {24'h0, v};
		wait_rdy;
	endtask : bus

	// Data-phase watcher takes the oldest expected read word
	always @(posedge clk) begin
		if (dph) begin
			chk_pin("hresp", 8'h00, {7'h0, hresp});
			if (exp_q.size() > 0) chk_rd(exp_q.pop_front(), hrdata);
		end
		dph <= !rst && hsel && htrans[1] && !hwr && hrdy;
	end

	// ==========================================================
	// Latch and direction mix read back through the port data address
	task automatic port_mix(input logic [5:0] di, ri, input logic [7:0] m, pin, input int k);
		logic [7:0] lat, dir, oe, o;
		lat = 8'($urandom()) & m;
		dir = (k == 0) ? 8'h00 : (k == 1) ? m : 8'($urandom()) & m;
		bus(1'b1, di, lat);
		bus(1'b1, ri, dir);
		bus(1'b0, ri, dir);
		repeat (4) @(posedge clk);
		bus(1'b0, di, (lat & dir) | (pin & ~dir & m));
		oe = (ri == gpcde_pkg::IDX_PORTC_DIR) ? {2'h0, pcoe} :
			(ri == gpcde_pkg::IDX_PORTD_DIR) ? pdoe : peoe;
		o = (ri == gpcde_pkg::IDX_PORTC_DIR) ? {2'h0, pco} :
			(ri == gpcde_pkg::IDX_PORTD_DIR) ? pdo : peo;
		chk_pin("oe_n", ~dir & m, oe & m);
		chk_pin("out", lat & dir, o & dir);
	endtask : port_mix

	// Peripherals take port E pins over in random modes
	task automatic pe_mix;
		logic [7:0] lat, dir, own, poe, pout, oen, drv, pw;
		lat = 8'($urandom());
		dir = 8'($urandom());
		bus(1'b1, gpcde_pkg::IDX_PORTE_DATA, lat);
		bus(1'b1, gpcde_pkg::IDX_PORTE_DIR, dir);
		{spi_enable_bit, spm, sce, soe, sout, els0, els1, coe, cout, txd} <= 18'($urandom());
		repeat (5) @(posedge clk);
		own = {{3{spi_enable_bit}}, spi_enable_bit & ~spm, els1 != 2'h0, els0 != 2'h0, sce, sce};
		poe = {soe, 1'b0, coe, 1'b0, 1'b1};
		pout = {sout, 1'b0, cout, 1'b0, txd};
		oen = (own & ~poe) | (~own & ~dir);
		drv = ~oen;
		pw = (((own & pout) | (~own & lat)) & drv) | (~drv & ext_e);
		chk_pin("pe_oe_n", oen, peoe);
		chk_pin("pe_out", pw & drv, peo & drv);
		chk_pin("pe_level", pw, pel);
		bus(1'b0, gpcde_pkg::IDX_PORTE_DATA, (lat & dir) | (pw & ~dir));
	endtask : pe_mix

	// ==========================================================
	// Main sequence
	initial begin
		logic [7:0] v, w;
		rst = 1'b1;
		{hsel, hwr, sclk, spi_enable_bit, spm, sce, txd} = '0;
		{haddr, hwdata, htrans, els0, els1, coe, cout} = '0;
		{psa, psb, soe, sout, ext_c, ext_d, ext_e} = '0;
		hsize = gpcde_pkg::HSIZE_WORD;
		en_c = 6'h3f;
		en_d = 8'hff;
		en_e = 8'hff;
		error_cnt = 0;
		compares = 0;
		void'($urandom(16750));
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		chk_pin("pd_oe_n", 8'hff, pdoe);
		chk_pin("pe_oe_n", 8'hff, peoe);
		for (int k = 0; k < 6; k++) begin
			v = 8'($urandom());
			ext_c <= v[5:0];
			ext_d <= v;
			ext_e <= ~v;
			port_mix(gpcde_pkg::IDX_PORTC_DATA, gpcde_pkg::IDX_PORTC_DIR, 8'h3f, v, k);
			port_mix(gpcde_pkg::IDX_PORTD_DATA, gpcde_pkg::IDX_PORTD_DIR, 8'hff, v, k);
			port_mix(gpcde_pkg::IDX_PORTE_DATA, gpcde_pkg::IDX_PORTE_DIR, 8'hff, ~v, k);
		end
		// Pull-ups with the outside drivers released
		en_d <= 8'h00;
		for (int k = 0; k < 3; k++) begin
			v = 8'($urandom());
			w = 8'($urandom());
			bus(1'b1, gpcde_pkg::IDX_PORTD_DIR, 8'h00);
			bus(1'b1, gpcde_pkg::IDX_PORTD_PULLUP, v);
			bus(1'b1, gpcde_pkg::IDX_PORTD_DIR, w);
			bus(1'b0, gpcde_pkg::IDX_PORTD_PULLUP, v);
			chk_pin("pullup", v & ~w, pdpu);
		end
		en_d <= 8'hff;
		// Timer clocks taken from port D pins
		bus(1'b1, gpcde_pkg::IDX_PORTD_DIR, 8'hff);
		for (int k = 0; k < 4; k++) begin
			v = 8'($urandom());
			ext_d <= v;
			psa <= k[0] ? 3'h7 : 3'($urandom() % 7);
			psb <= k[1] ? 3'h7 : 3'h3;
			repeat (5) @(posedge clk);
			chk_pin("ext_clk", {6'h0, k[0] & v[6], k[1] & v[4]}, {6'h0, tca, tcb});
			chk_pin("pd_oe_n", {1'b0, k[0], 1'b0, k[1], 4'h0}, pdoe);
		end
		// Clock out on port C pin 2, latch write there ignored
		bus(1'b1, gpcde_pkg::IDX_PORTC_DATA, 8'h00);
		bus(1'b1, gpcde_pkg::IDX_PORTC_DIR, 8'h84);
		bus(1'b1, gpcde_pkg::IDX_PORTC_DATA, 8'h3f);
		bus(1'b0, gpcde_pkg::IDX_PORTC_DIR, 8'h84);
		repeat (4) @(posedge clk);
		bus(1'b0, gpcde_pkg::IDX_PORTC_DATA, {2'h0, ext_c} & 8'h3b);
		chk_pin("pc_oe_n", 8'h3b, {2'h0, pcoe});
		for (int k = 0; k < 4; k++) begin
			sclk <= k[0];
			repeat (2) @(posedge clk);
			chk_pin("sysclk", {7'h0, k[0]}, {7'h0, pco[2]});
		end
		bus(1'b1, gpcde_pkg::IDX_PORTC_DIR, 8'h04);
		repeat (4) @(posedge clk);
		bus(1'b0, gpcde_pkg::IDX_PORTC_DATA, {2'h0, ext_c} & 8'h3b);
		for (int k = 0; k < 8; k++) begin
			pe_mix;
		end
		{spi_enable_bit, spm, sce, soe, sout, els0, els1, coe, cout, txd} <= 18'h0;
		// Second reset keeps latches, clears controls
		v = 8'($urandom());
		bus(1'b1, gpcde_pkg::IDX_PORTD_DATA, v);
		bus(1'b1, gpcde_pkg::IDX_PORTE_DATA, ~v);
		rst <= 1'b1;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		chk_pin("pd_oe_n", 8'hff, pdoe);
		bus(1'b0, gpcde_pkg::IDX_PORTD_DIR, 8'h00);
		bus(1'b0, gpcde_pkg::IDX_PORTC_DIR, 8'h00);
		bus(1'b0, gpcde_pkg::IDX_PORTD_PULLUP, 8'h00);
		bus(1'b1, gpcde_pkg::IDX_PORTD_DIR, 8'hff);
		bus(1'b1, gpcde_pkg::IDX_PORTE_DIR, 8'hff);
		// Byte-sized accesses are ignored: write dropped, read gives zero
		hsize <= 3'h0;
		bus(1'b1, gpcde_pkg::IDX_PORTD_DATA, ~v);
		bus(1'b0, gpcde_pkg::IDX_PORTD_DATA, 8'h00);
		hsize <= gpcde_pkg::HSIZE_WORD;
		bus(1'b0, gpcde_pkg::IDX_PORTD_DATA, v);
		bus(1'b0, gpcde_pkg::IDX_PORTE_DATA, ~v);
		bus(1'b0, 6'h3f, 8'h00);
		repeat (2) @(posedge clk);
		finish_test;
	end
endmodule : test_gpio_ports_c_d_e
